// >>> common/vtfs_regs.vh
// Register map, field positions, reset values and timing constants of the VT failure supervision block
`ifndef VTFS_REGS_VH
`define VTFS_REGS_VH

// Register byte addresses
`define VTFS_ADDR_CTRL      8'h00
`define VTFS_ADDR_DELAY     8'h04
`define VTFS_ADDR_CMD       8'h08
`define VTFS_ADDR_STATUS    8'h0C
`define VTFS_ADDR_IRQ_STAT  8'h10
`define VTFS_ADDR_IRQ_EN    8'h14
`define VTFS_ADDR_IRQ_CLR   8'h18

// Control register fields
`define VTFS_CTRL_RESP_LSB  0
`define VTFS_CTRL_SRC_LSB   2
`define VTFS_CTRL_AUTO_BIT  4
`define VTFS_CTRL_RST       5'h00

// Response selection codes
`define VTFS_RESP_DISABLED  2'h0
`define VTFS_RESP_BLOCKING  2'h1
`define VTFS_RESP_INDICATE  2'h2

// Detection source selection codes
`define VTFS_SRC_MEAS_MCB   2'h0
`define VTFS_SRC_MEAS_ONLY  2'h1
`define VTFS_SRC_MCB_ONLY   2'h2

// Command register: bit 0 requests a manual reset of the latch
`define VTFS_CMD_RESET_BIT  0

// Latch delay reset value in clock ticks
`define VTFS_DELAY_RST      32'h000F4240

// Interrupt status bits
`define VTFS_IRQ_LATCH      0
`define VTFS_IRQ_ALARM      1
`define VTFS_IRQ_CLEAR      2
`define VTFS_IRQ_W          3

// Phase voltage level detector thresholds in volts
`define VTFS_V_DROPOFF      8'h0A
`define VTFS_V_PICKUP       8'h1E

// Timing: clock rate in kHz and window lengths in ms
`define VTFS_CLK_KHZ        100000
`define VTFS_T_COLLAPSE_MS  40
`define VTFS_T_ENERGISE_MS  240
`define VTFS_T_DIST_MS      20

`endif

// >>> verilog/vtfs_timer.v
// Pickup timer: reports done once run has been high for limit clock ticks
`timescale 1ns/1ps
module vtfs_timer (
  input  wire        clk_sys,
  input  wire        arst_n,
  input  wire        run,
  input  wire [31:0] limit,
  output reg         done
);
  reg  [31:0] cnt_r;
  wire [31:0] cnt_nxt;

  assign cnt_nxt = cnt_r + 32'h00000001;

  // Count while running, restart from zero when run drops
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= 32'h00000000;
      done  <= 1'b0;
    end else if (!run) begin
      cnt_r <= 32'h00000000;
      done  <= 1'b0;
    end else if (!done) begin
      cnt_r <= cnt_nxt;
      if (cnt_nxt >= limit) begin
        done <= 1'b1;
      end
    end
  end
endmodule

// >>> verilog/vtfs_supervision.v
// VT failure supervision: detection, inhibits, timed latch, reset modes, responses and register port
//
// Behaviour
// R1 - Enabled-status current elements go non-directional on failure
// R2 - Overcurrent inhibits cancel a pending, unlatched block
// R3 - Block latches after delay; faults no longer clear
// R4 - Manual reset command clears latch once condition gone
// R5 - Auto mode clears latch when three phases live
// R6 - Response disabled, blocking or indication; blocking blocks
// R7 - Blocking response: alarm only after latch delay
// R8 - Indication: no blocking; acceleration trip gives early alarm
// R9 - Distance block from delayed fast block, poles-open
// R10 - Non-distance elements blocked by fast block output
// R11 - Breaker auxiliary input raises the failure block
// R12 - Poles open, phase overcurrent, NPS current inhibit
// R13 - Phase current change over one cycle inhibits
// R14 - Latch delay counted in ticks, restarts on drop
// R15 - Phase voltage detectors: drop-off 10 V, pickup 30 V
// R16 - Superimposed current acts only 40 ms after collapse
// R17 - Overcurrent inhibit active 240 ms after energisation
// R18 - Source: measurement plus breaker, measurement, breaker only
`timescale 1ns/1ps
`include "vtfs_regs.vh"
module vtfs_supervision #(
  parameter [31:0] COLLAPSE_CYC = `VTFS_T_COLLAPSE_MS * `VTFS_CLK_KHZ,
  parameter [31:0] ENERGISE_CYC = `VTFS_T_ENERGISE_MS * `VTFS_CLK_KHZ,
  parameter [31:0] DIST_CYC     = `VTFS_T_DIST_MS * `VTFS_CLK_KHZ
) (
  input  wire        clk_sys,
  input  wire        arst_n,
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  input  wire [23:0] phase_v_mag,
  input  wire        neg_seq_volt_det,
  input  wire        neg_seq_current_inhibit,
  input  wire        phase_overcurrent_inhibit,
  input  wire        superimposed_current_det,
  input  wire        all_poles_dead,
  input  wire        breaker_aux_input,
  input  wire        accel_trip,
  input  wire        vt_fail_enabled_status,
  output reg         vt_fail_fast_block,
  output reg         distance_block_out,
  output reg         vt_fail_alarm,
  output reg         element_nondirectional,
  output reg         irq
);
  // Register state
  reg  [4:0]  ctrl_r;
  reg  [31:0] latch_delay;
  reg  [2:0]  irq_stat_r;
  reg  [2:0]  irq_en_r;
  reg         reset_cmd_r;
  // Breaker input synchroniser and filtered level
  reg         mcb_s1_r;
  reg         mcb_s2_r;
  reg         mcb_s3_r;
  reg         mcb_r;
  // Phase level detectors and history
  reg  [2:0]  live_r;
  reg         dead_d_r;
  reg         apd_d_r;
  reg         collapse_win_r;
  reg         energise_win_r;
  reg         sup_block_r;
  // Failure state
  reg         latched_r;
  reg         alarm_early_r;

  wire [1:0]  resp_sel;
  wire [1:0]  src_sel;
  wire        auto_mode;
  wire        all_dead;
  wire        all_live;
  wire        nps_cond;
  wire        loss_cond;
  wire        meas_cond;
  wire        fail_cond;
  wire        inhibit;
  wire        pending;
  wire        active;
  wire        delay_done;
  wire        collapse_done;
  wire        energise_done;
  wire        dist_done;
  wire        latch_clr;
  wire        fb_nxt;
  wire        alarm_nxt;
  wire [2:0]  irq_ev;
  wire [2:0]  irq_clr;

  assign resp_sel  = ctrl_r[`VTFS_CTRL_RESP_LSB+1:`VTFS_CTRL_RESP_LSB];
  assign src_sel   = ctrl_r[`VTFS_CTRL_SRC_LSB+1:`VTFS_CTRL_SRC_LSB];
  assign auto_mode = ctrl_r[`VTFS_CTRL_AUTO_BIT];

  // Per-phase voltage detectors with hysteresis
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_phase
      always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          live_r[gi] <= 1'b0;
        end else if (phase_v_mag[gi*8+7:gi*8] >= `VTFS_V_PICKUP) begin
          live_r[gi] <= 1'b1; // R15
        end else if (phase_v_mag[gi*8+7:gi*8] < `VTFS_V_DROPOFF) begin
          live_r[gi] <= 1'b0; // R15
        end
      end
    end
  endgenerate

  assign all_dead = ~|live_r;
  assign all_live = &live_r;

  // Breaker auxiliary input: three flops, accept when last two agree
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mcb_s1_r <= 1'b0;
      mcb_s2_r <= 1'b0;
      mcb_s3_r <= 1'b0;
      mcb_r    <= 1'b0;
    end else begin
      mcb_s1_r <= breaker_aux_input;
      mcb_s2_r <= mcb_s1_r;
      mcb_s3_r <= mcb_s2_r;
      if (mcb_s2_r == mcb_s3_r) begin
        mcb_r <= mcb_s3_r;
      end
    end
  end

  // Window timers: collapse window, energisation window, distance delay and latch delay
  vtfs_timer u_collapse (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .run     (collapse_win_r),
    .limit   (COLLAPSE_CYC),
    .done    (collapse_done)
  );

  vtfs_timer u_energise (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .run     (energise_win_r),
    .limit   (ENERGISE_CYC),
    .done    (energise_done)
  );

  vtfs_timer u_dist (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .run     (vt_fail_fast_block),
    .limit   (DIST_CYC),
    .done    (dist_done)
  );

  vtfs_timer u_delay (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .run     (pending),
    .limit   (latch_delay),
    .done    (delay_done)
  );

  // Edge history and the two windows opened by edges
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dead_d_r       <= 1'b1;
      apd_d_r        <= 1'b0;
      collapse_win_r <= 1'b0;
      energise_win_r <= 1'b0;
      sup_block_r    <= 1'b0;
    end else begin
      dead_d_r <= all_dead;
      apd_d_r  <= all_poles_dead;
      // Voltage collapse opens the superimposed-current window
      if (all_dead && !dead_d_r) begin
        collapse_win_r <= 1'b1; // R16
      end else if (collapse_done || !all_dead) begin
        collapse_win_r <= 1'b0; // R16
      end
      // Poles-open release opens the overcurrent window
      if (apd_d_r && !all_poles_dead) begin
        energise_win_r <= 1'b1; // R17
      end else if (energise_done || all_poles_dead) begin
        energise_win_r <= 1'b0; // R17
      end
      // Current change inside the window vetoes the three-phase loss
      if (!all_dead) begin
        sup_block_r <= 1'b0;
      end else if (collapse_win_r && superimposed_current_det) begin
        sup_block_r <= 1'b1; // R16
      end
    end
  end

  // Detection conditions and source selection
  assign nps_cond  = neg_seq_volt_det & ~neg_seq_current_inhibit;
  assign loss_cond = all_dead & ~sup_block_r & ~superimposed_current_det; // R13
  assign meas_cond = nps_cond | loss_cond;
  assign fail_cond = (src_sel == `VTFS_SRC_MEAS_ONLY) ? meas_cond :
                     (src_sel == `VTFS_SRC_MCB_ONLY)  ? mcb_r :
                     (meas_cond | mcb_r); // R11 R18

  // Inhibits only hold off detection, never a latched block
  assign inhibit = all_poles_dead | neg_seq_current_inhibit | superimposed_current_det |
                   (phase_overcurrent_inhibit & energise_win_r); // R2 R12 R13 R17
  assign pending = fail_cond & ~inhibit & ~latched_r & (resp_sel != `VTFS_RESP_DISABLED); // R2 R14
  assign active  = pending | latched_r;

  // Latch release by mode
  assign latch_clr = auto_mode ? all_live : (reset_cmd_r & ~fail_cond); // R4 R5

  // Latch after delay; latched block ignores later fault detection
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      latched_r <= 1'b0;
    end else if (resp_sel == `VTFS_RESP_DISABLED) begin
      latched_r <= 1'b0;
    end else if (pending && delay_done) begin
      latched_r <= 1'b1; // R3 R14
    end else if (latched_r && latch_clr) begin
      latched_r <= 1'b0; // R4 R5
    end
  end

  // Early alarm in indication mode on acceleration trip
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      alarm_early_r <= 1'b0;
    end else if (resp_sel != `VTFS_RESP_INDICATE || !active) begin
      alarm_early_r <= 1'b0;
    end else if (pending && accel_trip) begin
      alarm_early_r <= 1'b1; // R8
    end
  end

  assign fb_nxt    = (resp_sel == `VTFS_RESP_BLOCKING) & active; // R6 R8 R10
  assign alarm_nxt = latched_r | alarm_early_r; // R7 R8

  // Outputs to protection elements
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      vt_fail_fast_block     <= 1'b0;
      distance_block_out     <= 1'b0;
      vt_fail_alarm          <= 1'b0;
      element_nondirectional <= 1'b0;
    end else begin
      vt_fail_fast_block     <= fb_nxt; // R10
      // Delayed fast block, or immediately while poles are open or the line is being energised
      distance_block_out     <= vt_fail_fast_block & (dist_done | energise_win_r | apd_d_r); // R9
      vt_fail_alarm          <= alarm_nxt; // R7
      element_nondirectional <= active & vt_fail_enabled_status &
                                (resp_sel != `VTFS_RESP_DISABLED); // R1
    end
  end

  // Interrupt events: latch set, alarm rise, latch cleared
  assign irq_ev  = {latched_r & latch_clr & (resp_sel != `VTFS_RESP_DISABLED),
                    alarm_nxt & ~vt_fail_alarm,
                    pending & delay_done};
  assign irq_clr = (reg_wr && reg_addr == `VTFS_ADDR_IRQ_CLR) ? reg_wdata[`VTFS_IRQ_W-1:0] : 3'h0;

  // Register writes, sticky status with set winning over clear
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r      <= `VTFS_CTRL_RST;
      latch_delay <= `VTFS_DELAY_RST;
      irq_en_r    <= 3'h0;
      irq_stat_r  <= 3'h0;
      reset_cmd_r <= 1'b0;
      irq         <= 1'b0;
    end else begin
      reset_cmd_r <= 1'b0;
      if (reg_wr) begin
        if (reg_addr == `VTFS_ADDR_CTRL) begin
          ctrl_r <= reg_wdata[4:0];
        end else if (reg_addr == `VTFS_ADDR_DELAY) begin
          latch_delay <= reg_wdata;
        end else if (reg_addr == `VTFS_ADDR_CMD) begin
          reset_cmd_r <= reg_wdata[`VTFS_CMD_RESET_BIT]; // R4
        end else if (reg_addr == `VTFS_ADDR_IRQ_EN) begin
          irq_en_r <= reg_wdata[`VTFS_IRQ_W-1:0];
        end
      end
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
      irq        <= |(((irq_stat_r & ~irq_clr) | irq_ev) & irq_en_r);
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (!reg_rd) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_addr == `VTFS_ADDR_CTRL) begin
      reg_rdata <= {27'h0000000, ctrl_r};
    end else if (reg_addr == `VTFS_ADDR_DELAY) begin
      reg_rdata <= latch_delay;
    end else if (reg_addr == `VTFS_ADDR_STATUS) begin
      reg_rdata <= {21'h000000, energise_win_r, mcb_r, live_r, element_nondirectional,
                    vt_fail_alarm, distance_block_out, vt_fail_fast_block, pending, latched_r};
    end else if (reg_addr == `VTFS_ADDR_IRQ_STAT) begin
      reg_rdata <= {29'h00000000, irq_stat_r};
    end else if (reg_addr == `VTFS_ADDR_IRQ_EN) begin
      reg_rdata <= {29'h00000000, irq_en_r};
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end
endmodule

// >>> test/vtfs_meas_model.sv
// Measurement front end model: phase voltages and level detector flags
`timescale 1ns/1ps
module vtfs_meas_model (
  input  logic        clk_sys,
  input  logic        vt_loss,
  input  logic        vt_loss3,
  input  logic        sys_fault,
  input  logic        oc_fault,
  input  logic        cur_step,
  input  logic        poles_open,
  input  logic        mcb_open,
  output logic [23:0] phase_v_mag,
  output logic        neg_seq_volt_det,
  output logic        neg_seq_current_inhibit,
  output logic        phase_overcurrent_inhibit,
  output logic        superimposed_current_det,
  output logic        all_poles_dead,
  output logic        breaker_aux_input
);
  // Flags follow the commanded plant state one edge later
  always @(posedge clk_sys) begin
    phase_v_mag <= vt_loss3 ? 24'h000000 : (vt_loss ? 24'h3F3F00 : 24'h3F3F3F);
    neg_seq_volt_det <= vt_loss;
    neg_seq_current_inhibit <= sys_fault;
    phase_overcurrent_inhibit <= sys_fault | oc_fault;
    superimposed_current_det <= cur_step;
    all_poles_dead <= poles_open;
    breaker_aux_input <= mcb_open;
  end

  // Healthy live line at time zero, no current change, poles closed
  initial begin
    phase_v_mag = 24'h3F3F3F;
    neg_seq_volt_det = 1'b0;
    neg_seq_current_inhibit = 1'b0;
    phase_overcurrent_inhibit = 1'b0;
    superimposed_current_det = 1'b0;
    all_poles_dead = 1'b0;
    breaker_aux_input = 1'b0;
  end
endmodule

// >>> test/vtfs_supervision_props.sv
// Port-level property checker for the VT failure supervision block
`timescale 1ns/1ps
`include "vtfs_regs.vh"
module vtfs_supervision_props (
  input logic        clk_sys,
  input logic        arst_n,
  input logic [7:0]  reg_addr,
  input logic [31:0] reg_wdata,
  input logic        reg_wr,
  input logic        reg_rd,
  input logic [31:0] reg_rdata,
  input logic        neg_seq_current_inhibit,
  input logic        breaker_aux_input,
  input logic        vt_fail_enabled_status,
  input logic        vt_fail_fast_block,
  input logic        distance_block_out,
  input logic        vt_fail_alarm,
  input logic        element_nondirectional,
  input logic        irq
);
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  // Bus read data and output relations
  a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not zero when idle");
  a_nondir_needs_en: assert property (element_nondirectional |-> $past(vt_fail_enabled_status))
    else $error("nondirectional without enabled status");
  a_rise_not_inhib: assert property ($rose(vt_fail_fast_block) && !$past(breaker_aux_input, 3)
    |-> !$past(neg_seq_current_inhibit)) else $error("block raised under current inhibit");
  a_alarm_after_blk: assert property ($rose(vt_fail_alarm) && vt_fail_fast_block
    |-> $past(vt_fail_fast_block, 2)) else $error("blocking alarm too early");
  a_dist_from_fast: assert property ($rose(distance_block_out) |-> $past(vt_fail_fast_block))
    else $error("distance block without fast block");
  a_irq_mask_off: assert property (reg_wr && reg_addr == `VTFS_ADDR_IRQ_EN && reg_wdata[2:0] == 3'h0
    |-> ##2 !irq) else $error("irq high with all enables off");
  a_off_quiet: assert property (reg_wr && reg_addr == `VTFS_ADDR_CTRL && reg_wdata[1:0] == 2'h0
    |-> ##3 !vt_fail_fast_block && !vt_fail_alarm) else $error("outputs active when disabled");
  a_indic_no_block: assert property (reg_wr && reg_addr == `VTFS_ADDR_CTRL && reg_wdata[1:0] == 2'h2
    |-> ##2 (!vt_fail_fast_block) [*4]) else $error("block raised in indication mode");

  // Main scenarios reached
  c_alarm: cover property ($rose(vt_fail_alarm));
  c_irq: cover property ($rose(irq));
  c_nondir: cover property ($rose(element_nondirectional));
endmodule

bind vtfs_supervision vtfs_supervision_props u_props (
  .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .neg_seq_current_inhibit(neg_seq_current_inhibit),
  .breaker_aux_input(breaker_aux_input), .vt_fail_enabled_status(vt_fail_enabled_status),
  .vt_fail_fast_block(vt_fail_fast_block), .distance_block_out(distance_block_out),
  .vt_fail_alarm(vt_fail_alarm), .element_nondirectional(element_nondirectional), .irq(irq));

// >>> test/tb_vt_failure_supervision_logic.sv
// Directed testbench for the VT failure supervision block
`timescale 1ns/1ps
`include "vtfs_regs.vh"
module tb_vt_failure_supervision_logic;
  logic        clk_sys = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        vt_loss = 1'b0;
  logic        sys_fault = 1'b0;
  logic        mcb_open = 1'b0;
  logic        accel_trip = 1'b0;
  logic        nd_en = 1'b0;
  logic        l3 = 1'b0;
  logic        cs = 1'b0;
  logic        po = 1'b0;
  logic        oc = 1'b0;
  wire  [31:0] reg_rdata;
  wire  [23:0] pv;
  wire         nsv, nsi, poi, sid, apd, bai, fb, db, al, nd, irq;
  int          err_count = 0;
  int          tests_run = 0;

  // System clock
  always #5 clk_sys = ~clk_sys;

  vtfs_meas_model u_meas (.clk_sys(clk_sys), .vt_loss(vt_loss), .vt_loss3(l3), .sys_fault(sys_fault),
    .oc_fault(oc), .cur_step(cs), .poles_open(po), .mcb_open(mcb_open),
    .phase_v_mag(pv), .neg_seq_volt_det(nsv), .neg_seq_current_inhibit(nsi), .phase_overcurrent_inhibit(poi),
    .superimposed_current_det(sid), .all_poles_dead(apd), .breaker_aux_input(bai));

  vtfs_supervision #(.COLLAPSE_CYC(32'h14), .ENERGISE_CYC(32'h32), .DIST_CYC(32'h0A)) u_dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .phase_v_mag(pv), .neg_seq_volt_det(nsv),
    .neg_seq_current_inhibit(nsi), .phase_overcurrent_inhibit(poi), .superimposed_current_det(sid),
    .all_poles_dead(apd), .breaker_aux_input(bai), .accel_trip(accel_trip), .vt_fail_enabled_status(nd_en),
    .vt_fail_fast_block(fb), .distance_block_out(db), .vt_fail_alarm(al), .element_nondirectional(nd), .irq(irq));

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // One-cycle read, data checked in the following cycle
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask

  // Wait n edges, then settle
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // Plant state for the front end model and element inputs
  task automatic plant(input logic v, input logic f, input logic m, input logic a, input logic n);
    @(posedge clk_sys);
    vt_loss <= v;
    sys_fault <= f;
    mcb_open <= m;
    accel_trip <= a;
    nd_en <= n;
  endtask

  // Three-phase loss, current step, poles open and overcurrent flags
  task automatic plant2(input logic l, input logic c, input logic p, input logic o);
    @(posedge clk_sys);
    l3 <= l;
    cs <= c;
    po <= p;
    oc <= o;
  endtask

  task automatic t_regs;
    rd(`VTFS_ADDR_CTRL, 32'h0);
    rd(`VTFS_ADDR_DELAY, `VTFS_DELAY_RST);
    rd(8'h20, 32'h0);
    wr(`VTFS_ADDR_DELAY, 32'h8);
    rd(`VTFS_ADDR_DELAY, 32'h8);
    $display("t_regs done");
  endtask

  task automatic t_block;
    wr(`VTFS_ADDR_CTRL, 32'h1);
    wr(`VTFS_ADDR_IRQ_EN, 32'h1);
    plant(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    wt(4);
    chk({fb, al}, 2'h2);
    wt(12);
    chk({fb, al, irq, db}, 4'hF);
    wr(`VTFS_ADDR_CMD, 32'h1);
    wt(3);
    chk(fb, 1'b1);
    plant(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    wt(4);
    chk(fb, 1'b1);
    plant(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    wt(3);
    chk(fb, 1'b1);
    wr(`VTFS_ADDR_CMD, 32'h1);
    wt(3);
    chk({fb, al}, 2'h0);
    wr(`VTFS_ADDR_IRQ_CLR, 32'h1);
    wt(2);
    chk(irq, 1'b0);
    rd(`VTFS_ADDR_IRQ_STAT, 32'h6);
    wr(`VTFS_ADDR_IRQ_CLR, 32'h7);
    wr(`VTFS_ADDR_IRQ_EN, 32'h0);
    $display("t_block done");
  endtask

  task automatic t_inhibit;
    plant(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    wt(20);
    chk({fb, al}, 2'h0);
    plant(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    wt(3);
    $display("t_inhibit done");
  endtask

  task automatic t_auto;
    wr(`VTFS_ADDR_CTRL, 32'h11);
    plant(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    wt(16);
    chk(fb, 1'b1);
    plant(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    wt(5);
    chk(fb, 1'b0);
    $display("t_auto done");
  endtask

  task automatic t_indic;
    wr(`VTFS_ADDR_DELAY, 32'h28);
    wr(`VTFS_ADDR_CTRL, 32'h2);
    plant(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    wt(4);
    chk({fb, al, nd}, 3'h1);
    plant(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    wt(4);
    chk({fb, al}, 2'h1);
    plant(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    wr(`VTFS_ADDR_CTRL, 32'h0);
    $display("t_indic done");
  endtask

  task automatic t_mcb;
    wr(`VTFS_ADDR_CTRL, 32'h9);
    plant(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    wt(10);
    chk(fb, 1'b1);
    wr(`VTFS_ADDR_CTRL, 32'h0);
    wt(2);
    chk({fb, al}, 2'h0);
    plant(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    $display("t_mcb done");
  endtask

  task automatic t_window;
    wt(6);
    wr(`VTFS_ADDR_CTRL, 32'h1);
    plant2(1'b0, 1'b1, 1'b0, 1'b0);
    plant(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    wt(12);
    chk(fb, 1'b0);
    plant2(1'b0, 1'b0, 1'b0, 1'b0);
    wt(4);
    chk(fb, 1'b1);
    plant(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    plant2(1'b0, 1'b0, 1'b1, 1'b0);
    plant(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    wt(12);
    chk(fb, 1'b0);
    plant2(1'b0, 1'b0, 1'b0, 1'b0);
    wt(3);
    chk({fb, db}, 2'h3);
    plant(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    wt(3);
    plant2(1'b0, 1'b0, 1'b0, 1'b1);
    plant(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    wt(8);
    chk(fb, 1'b0);
    wt(42);
    chk(fb, 1'b1);
    plant(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    plant2(1'b0, 1'b0, 1'b0, 1'b0);
    plant2(1'b1, 1'b1, 1'b0, 1'b0);
    wt(3);
    plant2(1'b1, 1'b0, 1'b0, 1'b0);
    wt(10);
    chk(fb, 1'b0);
    plant2(1'b0, 1'b0, 1'b0, 1'b0);
    wt(3);
    plant2(1'b1, 1'b0, 1'b0, 1'b0);
    wt(30);
    chk(fb, 1'b1);
    plant2(1'b1, 1'b1, 1'b0, 1'b0);
    wt(4);
    chk(fb, 1'b0);
    plant2(1'b1, 1'b0, 1'b0, 1'b0);
    wt(4);
    chk(fb, 1'b1);
    plant2(1'b0, 1'b0, 1'b0, 1'b0);
    wr(`VTFS_ADDR_CTRL, 32'h0);
    wt(3);
    $display("t_window done");
  endtask

  // Report counts and verdict, then stop
  task automatic give_verdict;
    $display("tests_run=%0d err_count=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_regs();
    t_block();
    t_inhibit();
    t_auto();
    t_indic();
    t_mcb();
    t_window();
    give_verdict();
  end

  // Watchdog on a hung run
  initial begin
    #50000;
    err_count++;
    give_verdict();
  end
endmodule
